// ### logic/pssr_regs.sv
// What this block does
// - Bit 0 enables early receive valid
// - Bit 8 reads serial sync, reset zero
// - Bit 13 link-drop forward strap, zero enabled
// - Bit 12 mirror strap, also bridge MAC select in bridge modes
// - Bits 11-9 report operating mode strap
// - Bits 3-2 report autoneg select strap
// - Bit 1 autoneg enable strap, zero enabled
// - Bit 0 MAC interface strap, RGMII/MII
`timescale 1ns/100ps
`default_nettype none
module pssr_regs
    import pssr_pkg::*;
#(
    parameter int ADDR_W = 9
) (
    input wire logic clk_sys, // 40 MHz system clock
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    input wire logic wb_we_i, // Wishbone write enable
    input wire logic [ADDR_W-1:0] wb_adr_i, // Wishbone byte address
    input wire logic [3:0] wb_sel_i, // Wishbone byte selects
    input wire logic [31:0] wb_dat_i, // Wishbone write data
    output logic [31:0] wb_dat_o, // Wishbone read data
    output logic wb_ack_o, // Wishbone acknowledge
    input wire logic serial_sync_raw, // Serial link sync level, async
    input wire logic [PSSR_STRAP_WIDTH-1:0] strap_pins, // Strap pin levels, async
    output logic early_receive_valid_enable, // Early RX valid at 100 Mbps
    output logic serial_sync_up, // Synchronised serial sync level
    output pssr_strap_t strap_cfg, // Latched strap set
    output logic bridge_mac_select // MAC interface choice in bridge modes
);

    // Elaboration check: the highest register index must be addressable
    if (ADDR_W < 9) begin : g_addr_check
        $error("pssr_regs: ADDR_W must be at least 9");
    end

    // Address compare against a register index
    function automatic logic hit_index(input logic [ADDR_W-1:0] adr, input logic [7:0] idx);
        hit_index = (adr[ADDR_W-1:2] == (ADDR_W-2)'(idx));
    endfunction

    // Byte-lane write merge limited to the writable bits
    function automatic logic [15:0] merge_write(input logic [15:0] old, input logic [15:0] wdat,
                                                input logic [1:0] sel, input logic [15:0] wmask);
        logic [15:0] lane;
        lane = {{8{sel[1]}}, {8{sel[0]}}} & wmask;
        merge_write = (old & ~lane) | (wdat & lane);
    endfunction

    // Storage
    logic [15:0] low_latency_rx_config;
    logic [15:0] serial_sync_status;
    logic sync_meta1;
    logic sync_meta2;
    pssr_strap_t strap_meta1;
    pssr_strap_t strap_meta2;
    pssr_cap_state_t cap_state;
    logic [1:0] cap_count;

    // Bus decode
    wire logic bus_req = wb_cyc_i & wb_stb_i;
    wire logic hit_low_latency = hit_index(wb_adr_i, PSSR_IDX_LOW_LATENCY);
    wire logic hit_serial_sync = hit_index(wb_adr_i, PSSR_IDX_SERIAL_SYNC);
    wire logic hit_strap_latch = hit_index(wb_adr_i, PSSR_IDX_STRAP_LATCH);
    wire logic wr_commit = bus_req & wb_we_i & wb_ack_o;
    wire logic next_ack = bus_req & ~wb_ack_o;

    // Strap latch timing
    wire logic cap_fire = (cap_state == PSSR_CAP_WAIT) && (cap_count == PSSR_STRAP_SETTLE_CYCLES);
    wire logic [1:0] next_cap_count = (cap_state == PSSR_CAP_WAIT) ? cap_count + 2'h1 : cap_count;

    // Next register values; only the writable masks pass write data
    wire logic [15:0] next_low_latency = (wr_commit && hit_low_latency) ?
        merge_write(low_latency_rx_config, wb_dat_i[15:0], wb_sel_i[1:0], PSSR_WMASK_LOW_LATENCY) :
        low_latency_rx_config;
    wire logic [15:0] next_serial_sync = (wr_commit && hit_serial_sync) ?
        merge_write(serial_sync_status, wb_dat_i[15:0], wb_sel_i[1:0], PSSR_WMASK_SERIAL_SYNC) :
        serial_sync_status;

    // Readback words with live sync status and latched straps
    wire logic [15:0] rd_serial_sync = {serial_sync_status[15:9], serial_sync_up,
                                        serial_sync_status[7:0]};
    wire logic [15:0] rd_strap_latch = {2'h0, strap_cfg};
    wire logic [15:0] read_word = hit_low_latency ? low_latency_rx_config :
                                  hit_serial_sync ? rd_serial_sync :
                                  hit_strap_latch ? rd_strap_latch : 16'h0000;

    // Bridge modes route the mirror strap to the MAC interface choice
    wire logic bridge_mode = (strap_cfg.operating_mode_cfg == PSSR_OPM_RGMII_SGMII_BRIDGE) ||
                             (strap_cfg.operating_mode_cfg == PSSR_OPM_SGMII_COPPER);
    wire logic next_bridge_sel = bridge_mode & strap_cfg.mirror_mode_cfg;

    // Wishbone slave: single-wait acknowledge, data registered with it
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= next_ack;
            wb_dat_o <= next_ack ? {16'h0000, read_word} : wb_dat_o;
        end
    end

    // Software registers
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            low_latency_rx_config <= PSSR_RST_LOW_LATENCY;
            serial_sync_status <= PSSR_RST_SERIAL_SYNC;
        end else begin
            low_latency_rx_config <= next_low_latency;
            serial_sync_status <= next_serial_sync;
        end
    end

    // Configuration output registered from the next value of the stored bit
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            early_receive_valid_enable <= 1'b0;
        end else begin
            early_receive_valid_enable <= next_low_latency[PSSR_POS_EARLY_RX_VALID];
        end
    end

    // Three-flop synchroniser for the serial sync level
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            sync_meta1 <= 1'b0;
            sync_meta2 <= 1'b0;
            serial_sync_up <= 1'b0;
        end else begin
            sync_meta1 <= serial_sync_raw;
            sync_meta2 <= sync_meta1;
            serial_sync_up <= sync_meta2;
        end
    end

    // Two-flop synchroniser for the strap pins
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            strap_meta1 <= pssr_strap_t'(PSSR_RST_STRAP_LATCH[PSSR_STRAP_WIDTH-1:0]);
            strap_meta2 <= pssr_strap_t'(PSSR_RST_STRAP_LATCH[PSSR_STRAP_WIDTH-1:0]);
        end else begin
            strap_meta1 <= pssr_strap_t'(strap_pins);
            strap_meta2 <= strap_meta1;
        end
    end

    // Strap latch sequencer: one capture after release, then hold
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cap_state <= PSSR_CAP_WAIT;
            cap_count <= 2'h0;
        end else begin
            case (cap_state)
                PSSR_CAP_WAIT: begin
                    cap_count <= next_cap_count;
                    if (cap_fire) begin
                        cap_state <= PSSR_CAP_DONE;
                    end
                end
                PSSR_CAP_DONE: begin
                    cap_state <= PSSR_CAP_DONE;
                end
                default: begin
                    cap_state <= PSSR_CAP_WAIT;
                end
            endcase
        end
    end

    // Latched straps, untouched by bus writes
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            strap_cfg <= pssr_strap_t'(PSSR_RST_STRAP_LATCH[PSSR_STRAP_WIDTH-1:0]);
            bridge_mac_select <= 1'b0;
        end else begin
            strap_cfg <= cap_fire ? strap_meta2 : strap_cfg;
            bridge_mac_select <= next_bridge_sel;
        end
    end

    // Delay of the strap capture after the reset release
    localparam int CAP_LAT = int'(PSSR_STRAP_SETTLE_CYCLES) + 1;

    // Early receive valid is off after reset
    AST_ERV_RESET: assert property (@(posedge clk_sys)
        !reset_n |=> !early_receive_valid_enable)
        else $error("early receive valid not cleared by reset");

    // Early receive valid follows a committed low-byte write
    AST_ERV_WRITE: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (wr_commit && hit_low_latency && wb_sel_i[0])
        |=> early_receive_valid_enable == $past(wb_dat_i[0]))
        else $error("early receive valid did not follow the write");

    // A steady high sync level shows up three edges later
    AST_SYNC_FOLLOW: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (serial_sync_raw ##1 serial_sync_raw ##1 serial_sync_raw) |=> serial_sync_up)
        else $error("sync status did not follow the link");

    // Sync bit reads the live status and ignores write data
    AST_SYNC_READ: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (next_ack && hit_serial_sync)
        |=> wb_dat_o[PSSR_POS_SYNC_STATUS] == $past(serial_sync_up))
        else $error("sync bit readback mismatch");

    // Strap readback mirrors the latched set, top bits zero
    AST_STRAP_READ: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (next_ack && hit_strap_latch)
        |=> wb_dat_o[15:0] == {2'h0, $past(strap_cfg)})
        else $error("strap readback mismatch");

    // Straps are captured a fixed delay after reset release
    AST_STRAP_CAPTURE: assert property (@(posedge clk_sys) disable iff (!reset_n)
        ($past(!reset_n) && $past(!reset_n, 2) == 1'b0 || $rose(reset_n))
        |-> ##[CAP_LAT:CAP_LAT] (cap_state == PSSR_CAP_DONE))
        else $error("strap capture not done on time");

    // Latched straps hold once captured
    AST_STRAP_HOLD: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (cap_state == PSSR_CAP_DONE) |=> $stable(strap_cfg))
        else $error("latched straps changed after capture");

    // Writes to the strap register leave the straps alone
    AST_STRAP_RO: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (wr_commit && hit_strap_latch && !cap_fire) |=> $stable(strap_cfg))
        else $error("write altered a read-only strap field");

    // Read-only top nibble of the low-latency register stays zero
    AST_LLRC_TOP: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wr_commit && hit_low_latency |=> low_latency_rx_config[15:12] == 4'h0)
        else $error("read-only bits of low-latency register changed");

    // Bridge MAC choice tracks the mirror strap in bridge modes
    AST_BRIDGE_SEL: assert property (@(posedge clk_sys) disable iff (!reset_n)
        ##1 bridge_mac_select == $past(bridge_mode && strap_cfg.mirror_mode_cfg))
        else $error("bridge MAC selection mismatch");

    // Link-drop, autoneg and MAC bits sit at their readback positions
    AST_STRAP_BITS: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (next_ack && hit_strap_latch)
        |=> wb_dat_o[13] == $past(strap_cfg.link_drop_forward_cfg) &&
            wb_dat_o[3:2] == $past(strap_cfg.autoneg_select_cfg) &&
            wb_dat_o[1] == $past(strap_cfg.autoneg_enable_cfg) &&
            wb_dat_o[0] == $past(strap_cfg.mac_if_mii_cfg))
        else $error("strap bit placement mismatch");

    // Acknowledge is a single cycle per request
    AST_ACK_PULSE: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge held longer than one cycle");

    // Every request is answered at the next edge
    AST_ACK_ANSWER: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (bus_req && !wb_ack_o) |=> wb_ack_o)
        else $error("request not acknowledged in one cycle");

    // No acknowledge without a request in the cycle before
    AST_ACK_CAUSE: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !bus_req |=> !wb_ack_o)
        else $error("acknowledge without a request");

    // Sync status comes out of reset low
    AST_SYNC_RESET: assert property (@(posedge clk_sys)
        !reset_n |=> !serial_sync_up)
        else $error("sync status not cleared by reset");

    // Low-latency register returns to its reset value
    AST_LLRC_RESET: assert property (@(posedge clk_sys)
        !reset_n |=> low_latency_rx_config == PSSR_RST_LOW_LATENCY)
        else $error("low-latency register not at reset value");

    // Latched straps are cleared while reset is held
    AST_STRAP_RESET: assert property (@(posedge clk_sys)
        !reset_n |=> strap_cfg == pssr_strap_t'(PSSR_RST_STRAP_LATCH[PSSR_STRAP_WIDTH-1:0]))
        else $error("latched straps not cleared by reset");

    // Reserved bits hold unless software writes the register
    AST_LLRC_HOLD: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !(wr_commit && hit_low_latency) |=> $stable(low_latency_rx_config))
        else $error("low-latency register changed without a write");

    // Early receive valid only moves on a register write
    AST_ERV_HOLD: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !(wr_commit && hit_low_latency) |=> $stable(early_receive_valid_enable))
        else $error("early receive valid changed without a write");

    // Stored sync bits hold unless software writes them
    AST_SYNC_HOLD: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !(wr_commit && hit_serial_sync) |=> $stable(serial_sync_status))
        else $error("sync register changed without a write");

    // Read-only fields of the sync register read zero
    AST_SYNC_ZERO: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (next_ack && hit_serial_sync)
        |=> wb_dat_o[31:16] == 16'h0000 && wb_dat_o[10:9] == 2'h0 && wb_dat_o[7:0] == 8'h00)
        else $error("read-only sync bits not zero");

    // Unmapped places read zero
    AST_UNMAPPED_READ: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (next_ack && !hit_low_latency && !hit_serial_sync && !hit_strap_latch)
        |=> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");

endmodule
`default_nettype wire

// ### logic/pssr_pkg.sv
`default_nettype none
package pssr_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] PSSR_IDX_LOW_LATENCY = 8'h43;
    localparam logic [7:0] PSSR_IDX_SERIAL_SYNC = 8'h4F;
    localparam logic [7:0] PSSR_IDX_STRAP_LATCH = 8'h6E;

    // Reset values
    localparam logic [15:0] PSSR_RST_LOW_LATENCY = 16'h07A0;
    localparam logic [15:0] PSSR_RST_SERIAL_SYNC = 16'h0000;
    localparam logic [15:0] PSSR_RST_STRAP_LATCH = 16'h0000;

    // Writable bit masks
    localparam logic [15:0] PSSR_WMASK_LOW_LATENCY = 16'h0FFF;
    localparam logic [15:0] PSSR_WMASK_SERIAL_SYNC = 16'hF800;

    // Field positions
    localparam int PSSR_POS_EARLY_RX_VALID = 0;
    localparam int PSSR_POS_SYNC_STATUS = 8;
    localparam int PSSR_STRAP_WIDTH = 14;

    // Cycles after reset release before the straps are latched
    localparam logic [1:0] PSSR_STRAP_SETTLE_CYCLES = 2'h2;

    // Operating mode encodings
    typedef enum logic [2:0] {
        PSSR_OPM_RGMII_COPPER = 3'h0,
        PSSR_OPM_RGMII_1000X = 3'h1,
        PSSR_OPM_RGMII_100FX = 3'h2,
        PSSR_OPM_RGMII_SGMII_BRIDGE = 3'h3,
        PSSR_OPM_1000T_1000X = 3'h4,
        PSSR_OPM_100T_100FX = 3'h5,
        PSSR_OPM_SGMII_COPPER = 3'h6,
        PSSR_OPM_JTAG_SCAN = 3'h7
    } pssr_opmode_t;

    // Strap set, packed in the order of the strap status bits 13..0
    typedef struct packed {
        logic link_drop_forward_cfg;
        logic mirror_mode_cfg;
        pssr_opmode_t operating_mode_cfg;
        logic [4:0] management_address_cfg;
        logic [1:0] autoneg_select_cfg;
        logic autoneg_enable_cfg;
        logic mac_if_mii_cfg;
    } pssr_strap_t;

    // Strap latch sequencer
    typedef enum logic {
        PSSR_CAP_WAIT,
        PSSR_CAP_DONE
    } pssr_cap_state_t;
endpackage
`default_nettype wire

// ### testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    import pssr_pkg::*;
    logic clk_sys;
    logic reset_n;
    logic wb_cyc_i;
    logic wb_stb_i;
    logic wb_we_i;
    logic serial_sync_raw;
    logic wb_ack_o;
    logic early_receive_valid_enable;
    logic serial_sync_up;
    logic bridge_mac_select;
    logic [8:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic [13:0] strap_pins;
    logic [13:0] pins;
    logic bridge_exp;
    pssr_strap_t strap_cfg;
    logic [31:0] exp_q[$];
    int n_errors = 0;
    int checks = 0;
    int seed = 26;

    pssr_regs u_pssr_regs (
        .clk_sys(clk_sys), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .serial_sync_raw(serial_sync_raw),
        .strap_pins(strap_pins), .early_receive_valid_enable(early_receive_valid_enable),
        .serial_sync_up(serial_sync_up), .strap_cfg(strap_cfg),
        .bridge_mac_select(bridge_mac_select)
    );

    // Clock, 25 ns period
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // Compare one value with its expectation
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("Checks %0d, mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // One classic Wishbone cycle, held until ack
    task automatic bus(input logic we, input logic [8:0] a, input logic [3:0] s,
                       input logic [15:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= {16'hFFFF, d};
        // Only the watchdog ends a wait in which no acknowledge comes
        do begin
            @(posedge clk_sys);
        end while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_sys);
    endtask

    // Read with expectation noted for the monitor
    task automatic rd(input logic [8:0] a, input logic [15:0] exp);
        exp_q.push_back({16'h0000, exp});
        bus(1'b0, a, 4'hF, 16'h0000);
    endtask

    task automatic do_reset(input logic [13:0] p);
        reset_n <= 1'b0;
        strap_pins <= p;
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (5) @(posedge clk_sys);
    endtask

    // Monitor: read data compared at the ack edge
    always @(posedge clk_sys) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            if (exp_q.size() == 0) begin
                n_errors++;
                $display("FAIL t=%0t unexpected read", $time);
            end else
                check(wb_dat_o, exp_q.pop_front());
        end
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        $display("FAIL t=%0t timeout", $time);
        results();
    end

    // Main sequence
    initial begin
        reset_n = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 9'h000;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h00000000;
        serial_sync_raw = 1'b0;
        strap_pins = 14'h0000;
        pins = 14'h0000;
        // Every operating mode with both mirror levels, random other straps
        for (int m = 0; m < 16; m++) begin
            pins = 14'($random(seed));
            pins[12:9] = m[3:0];
            bridge_exp = (pins[11:9] == 3'h3 || pins[11:9] == 3'h6) && pins[12];
            do_reset(pins);
            check(32'(strap_cfg), {18'h0, pins});
            check(32'(bridge_mac_select), {31'h0, bridge_exp});
            rd(9'h1B8, {2'b00, pins});
        end
        // Straps hold after capture; writes ignored
        strap_pins <= ~pins;
        repeat (4) @(posedge clk_sys);
        check(32'(strap_cfg), {18'h0, pins});
        bus(1'b1, 9'h1B8, 4'hF, 16'hFFFF);
        rd(9'h1B8, {2'b00, pins});
        // Low latency register, byte lanes
        rd(9'h10C, 16'h07A0);
        check(32'(early_receive_valid_enable), 32'h0);
        bus(1'b1, 9'h10C, 4'h3, 16'hFFFF);
        rd(9'h10C, 16'h0FFF);
        check(32'(early_receive_valid_enable), 32'h1);
        bus(1'b1, 9'h10C, 4'h1, 16'h0000);
        rd(9'h10C, 16'h0F00);
        check(32'(early_receive_valid_enable), 32'h0);
        // Sync status, live bit and stored reserved bits
        rd(9'h13C, 16'h0000);
        bus(1'b1, 9'h13C, 4'h3, 16'hFFFF);
        rd(9'h13C, 16'hF800);
        serial_sync_raw <= 1'b1;
        repeat (5) @(posedge clk_sys);
        check(32'(serial_sync_up), 32'h1);
        rd(9'h13C, 16'hF900);
        serial_sync_raw <= 1'b0;
        repeat (5) @(posedge clk_sys);
        rd(9'h13C, 16'hF800);
        // Unmapped place reads zero
        bus(1'b1, 9'h004, 4'hF, 16'hFFFF);
        rd(9'h004, 16'h0000);
        repeat (2) @(posedge clk_sys);
        results();
    end
endmodule
`default_nettype wire
